// ==== src/mcas_sequencer.sv ====
// sequencer, result registers, pwm sync and axi4-lite slave of the
// motor current adc; the analog converter core sits outside, returns
// its code on adc_code_in on the same clock, the start pin is async
//
// Notes on behaviour
// - each channel result is an 11-bit twos complement code
// - acquisition lasts 20 clocks regardless of channel count
// - all inputs held together, then channels converted one at a time
// - each channel conversion takes 40 clocks
// - group chosen in control register, never fewer than two channels
// - a group starts only on a conversion start request
// - one-clock sync pulse at each pwm cycle start, may trigger start
// - all counts run on the system clock
// - interrupt pin only pulls low, external pull-up releases it
// - reset default converts v and w; control bit 3 selects four
// - control bit 7 enables done interrupt, status bit 0; read clears
// - start within 20 clocks after a group waits for reacquisition
// - results left justified, lsb forced to zero
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
module mcas_sequencer #(
  parameter int ADDR_W = 8,
  parameter logic [11:0] PWM_PERIOD_INIT = mcas_pkg::PWM_PERIOD_RESET
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter pins and core
  input wire logic conversion_start_in,
  input wire logic [mcas_pkg::RESULT_BITS-1:0] adc_code_in,
  output mcas_pkg::mcas_seq_t seq_o,
  // pwm sync and open-drain interrupt
  output logic pwm_cycle_sync_out,
  output logic irq_n_o,
  output logic irq_oe_o
);

  function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
    idx_mapped = (a >> 6) == '0 && a[5:2] <= mcas_pkg::IDX_RES_AUX;
  endfunction

  mcas_pkg::mcas_state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [1:0] chan_q, chan_d;
  logic four_q, pend_q, accept, grp_done, res_we, defer_ev;
  logic start_s1_q, start_s2_q, start_s3_q;
  logic [11:0] ctrl_q, pwm_period_q, pwm_cnt_q;
  logic [1:0] status_q, status_d, int_en_q;
  logic [11:0] res_q [4];
  logic aw_full_q, w_full_q;
  logic [3:0] aw_idx_q;
  logic aw_ok_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic irq_d;

  // start pin is asynchronous: two flops, edge taken after the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
    end
    else
    begin
      start_s1_q <= conversion_start_in;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
    end
  end

  wire start_rise = start_s2_q & ~start_s3_q;
  wire sync_sel = ctrl_q[mcas_pkg::CTRL_SYNC_START_BIT];
  wire start_req = sync_sel ? pwm_cycle_sync_out : start_rise;
  assign defer_ev = start_req & (state_q == mcas_pkg::ST_ACQ);

  wire [1:0] first_chan = ctrl_q[mcas_pkg::CTRL_FOUR_CH_BIT] ?
    mcas_pkg::CH_U : mcas_pkg::CH_V;
  wire [1:0] last_chan = four_q ? mcas_pkg::CH_AUX : mcas_pkg::CH_W;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + 6'h01;
    chan_d = chan_q;
    accept = 1'b0;
    grp_done = 1'b0;
    res_we = 1'b0;
    case (state_q)
      mcas_pkg::ST_ACQ:
        if (cnt_q == mcas_pkg::ACQ_LAST)
        begin
          state_d = mcas_pkg::ST_IDLE;
          cnt_d = 6'h00;
        end
      mcas_pkg::ST_IDLE:
      begin
        cnt_d = 6'h00;
        if (pend_q)
        begin
          accept = 1'b1;
          state_d = mcas_pkg::ST_CONV;
          chan_d = first_chan;
        end
      end
      mcas_pkg::ST_CONV:
        if (cnt_q == mcas_pkg::CONV_LAST)
        begin
          res_we = 1'b1;
          cnt_d = 6'h00;
          if (chan_q == last_chan)
          begin
            grp_done = 1'b1;
            state_d = mcas_pkg::ST_ACQ;
          end
          else
            chan_d = chan_q + 2'h1;
        end
      default:
      begin
        state_d = mcas_pkg::ST_ACQ;
        cnt_d = 6'h00;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= mcas_pkg::ST_ACQ;
      cnt_q <= 6'h00;
      chan_q <= mcas_pkg::CH_V;
      four_q <= 1'b0;
      pend_q <= 1'b0;
      seq_o <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      // mode is frozen per group so a write mid-group cannot skew it
      if (accept)
        four_q <= ctrl_q[mcas_pkg::CTRL_FOUR_CH_BIT];
      // a new request in the accept cycle is kept, not lost
      pend_q <= start_req | (pend_q & ~accept);
      seq_o.hold <= state_d == mcas_pkg::ST_CONV;
      seq_o.busy <= state_d != mcas_pkg::ST_IDLE;
      seq_o.chan <= chan_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
        res_q[i] <= 12'h000;
    end
    else if (res_we)
      res_q[chan_q] <= {adc_code_in, 1'b0};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_cnt_q <= 12'h000;
      pwm_cycle_sync_out <= 1'b0;
    end
    else
    begin
      pwm_cnt_q <= (pwm_cnt_q == 12'h000) ? pwm_period_q - 12'h001
        : pwm_cnt_q - 12'h001;
      pwm_cycle_sync_out <= pwm_cnt_q == 12'h000;
    end
  end

  // axi write path: address and data taken in either order
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire [11:0] wmask = {{4{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [11:0] wval = wdata_q[11:0];
  wire wr_ctrl = do_write & aw_ok_q & aw_idx_q == mcas_pkg::IDX_CTRL;
  wire wr_clr = do_write & aw_ok_q & aw_idx_q == mcas_pkg::IDX_INT_CLEAR;
  wire wr_ien = do_write & aw_ok_q & aw_idx_q == mcas_pkg::IDX_INT_ENABLE;
  wire wr_pwm = do_write & aw_ok_q & aw_idx_q == mcas_pkg::IDX_PWM_PERIOD;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mcas_pkg::RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 4'h0;
      aw_ok_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[5:2];
        aw_ok_q <= idx_mapped(s_axi_awaddr);
      end
      if (w_fire)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_full_q & ~aw_fire & ~s_axi_bvalid;
      s_axi_wready <= ~w_full_q & ~w_fire & ~s_axi_bvalid;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok_q ? mcas_pkg::RESP_OKAY
          : mcas_pkg::RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software registers; bits 0 and 1 of control always stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= mcas_pkg::CTRL_RESET;
      int_en_q <= mcas_pkg::INT_EN_RESET;
      pwm_period_q <= PWM_PERIOD_INIT;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ((ctrl_q & ~wmask) | (wval & wmask))
          & mcas_pkg::CTRL_WMASK;
      if (wr_ien & wstrb_q[0])
        int_en_q <= wval[1:0];
      if (wr_pwm)
        pwm_period_q <= (pwm_period_q & ~wmask) | (wval & wmask);
    end
  end

  // axi read path
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  wire rd_ok = idx_mapped(s_axi_araddr);
  wire rd_status = ar_fire & rd_ok & rd_idx == mcas_pkg::IDX_STATUS;
  wire [11:0] rd_val =
    (rd_idx == mcas_pkg::IDX_CTRL) ? ctrl_q :
    (rd_idx == mcas_pkg::IDX_STATUS) ? {10'h000, status_q} :
    (rd_idx == mcas_pkg::IDX_INT_ENABLE) ? {10'h000, int_en_q} :
    (rd_idx == mcas_pkg::IDX_PWM_PERIOD) ? pwm_period_q :
    (rd_idx >= mcas_pkg::IDX_RES_U) ? res_q[2'(rd_idx - 4'h5)] :
    12'h000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mcas_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? {20'h00000, rd_val} : 32'h00000000;
        s_axi_rresp <= rd_ok ? mcas_pkg::RESP_OKAY
          : mcas_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  wire [1:0] ev = {defer_ev, grp_done};
  wire [1:0] clr = (wr_clr & wstrb_q[0] ? wval[1:0] : 2'h0)
    | {2{rd_status}};
  assign status_d = (status_q & ~clr) | ev;
  wire [1:0] en_eff = int_en_q
    & {1'b1, ctrl_q[mcas_pkg::CTRL_IRQ_EN_BIT]};
  assign irq_d = |(status_d & en_eff);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= mcas_pkg::STATUS_RESET;
      irq_oe_o <= 1'b0;
      irq_n_o <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_oe_o <= irq_d;
      irq_n_o <= 1'b0;
    end
  end

  // helper: cycles spent in the current group
  logic [7:0] grp_cyc_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_q != mcas_pkg::ST_CONV)
      grp_cyc_q <= 8'h00;
    else
      grp_cyc_q <= grp_cyc_q + 8'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ACQ_LEN: assert property (
    state_q == mcas_pkg::ST_IDLE && $past(state_q) == mcas_pkg::ST_ACQ
    |-> $past(cnt_q) == mcas_pkg::ACQ_LAST)
    else $error("acquisition not 20 cycles");
  AST_CONV_LEN: assert property (
    state_q == mcas_pkg::ST_CONV && $past(state_q) == mcas_pkg::ST_CONV
    && chan_q != $past(chan_q) |-> $past(cnt_q) == mcas_pkg::CONV_LAST)
    else $error("channel conversion not 40 cycles");
  AST_GROUP_LEN: assert property (
    grp_done |-> grp_cyc_q == (four_q ? 8'(4 * mcas_pkg::CONV_CYCLES - 1)
      : 8'(2 * mcas_pkg::CONV_CYCLES - 1)))
    else $error("group length wrong");
  AST_HOLD: assert property (
    state_q == mcas_pkg::ST_CONV |-> seq_o.hold && seq_o.busy)
    else $error("inputs not held during conversion");
  AST_START_CAUSE: assert property (
    state_q == mcas_pkg::ST_IDLE ##1 state_q == mcas_pkg::ST_CONV
    |-> $past(pend_q))
    else $error("group began without a request");
  AST_DEFER: assert property (
    state_q == mcas_pkg::ST_ACQ && start_req
    |=> state_q != mcas_pkg::ST_CONV && status_q[mcas_pkg::ST_DEFER_BIT])
    else $error("start during reacquisition not deferred");
  AST_SYNC_PULSE: assert property (
    pwm_cycle_sync_out && pwm_period_q != 12'h001
    |=> !pwm_cycle_sync_out)
    else $error("sync pulse longer than one clock");
  AST_IRQ_OD: assert property (
    !irq_n_o)
    else $error("interrupt pin drives high");
  AST_TWO_CH: assert property (
    state_q == mcas_pkg::ST_CONV && !four_q
    |-> chan_q == mcas_pkg::CH_V || chan_q == mcas_pkg::CH_W)
    else $error("two-channel mode converts wrong channel");
  AST_IRQ_DONE: assert property (
    grp_done && ctrl_q[mcas_pkg::CTRL_IRQ_EN_BIT] && int_en_q[0]
    |=> irq_oe_o && status_q[mcas_pkg::ST_DONE_BIT])
    else $error("done did not raise interrupt");
  AST_RESULT_LSB: assert property (
    res_we |=> res_q[$past(chan_q)] == {$past(adc_code_in), 1'b0})
    else $error("result not stored left justified");
  AST_RD_CLEAR: assert property (
    rd_status && !grp_done && !defer_ev |=> status_q == 2'h0)
    else $error("status read did not clear flags");

  COV_TWO_GROUP: cover property (grp_done && !four_q);
  COV_FOUR_GROUP: cover property (grp_done && four_q);
  COV_DEFERRED: cover property (defer_ev);
  COV_IRQ: cover property (irq_oe_o ##1 !irq_oe_o);

endmodule

// ==== src/mcas_pkg.sv ====
// constants, states and carrier types of the motor current adc sequencer
// assumes one 25 MHz system clock and a synchronous active-low reset
package mcas_pkg;

  // sequencer timing in system clock cycles, and the clock period in ns
  localparam int ACQ_CYCLES = 20;
  localparam int CONV_CYCLES = 40;
  localparam logic [5:0] ACQ_LAST = 6'(ACQ_CYCLES - 1);
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
  localparam int CLK_PERIOD_NS = 40;

  // result coding
  localparam int RESULT_BITS = 11;
  localparam int DATA_BITS = 12;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_INT_CLEAR = 4'h2;
  localparam logic [3:0] IDX_INT_ENABLE = 4'h3;
  localparam logic [3:0] IDX_PWM_PERIOD = 4'h4;
  localparam logic [3:0] IDX_RES_U = 4'h5;
  localparam logic [3:0] IDX_RES_V = 4'h6;
  localparam logic [3:0] IDX_RES_W = 4'h7;
  localparam logic [3:0] IDX_RES_AUX = 4'h8;

  // system control register fields
  localparam int CTRL_FOUR_CH_BIT = 3;
  localparam int CTRL_SYNC_START_BIT = 5;
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [11:0] CTRL_WMASK = 12'hFFC;

  // status / interrupt fields
  localparam int STATUS_BITS = 2;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_DEFER_BIT = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] INT_EN_RESET = 2'h3;

  // pwm cycle length in clocks
  localparam logic [11:0] PWM_PERIOD_RESET = 12'h4E2;

  // channel numbers
  localparam logic [1:0] CH_U = 2'h0;
  localparam logic [1:0] CH_V = 2'h1;
  localparam logic [1:0] CH_W = 2'h2;
  localparam logic [1:0] CH_AUX = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } mcas_state_t;

  // controls handed to the analog sample-and-hold and converter
  typedef struct packed {
    logic hold;
    logic busy;
    logic [1:0] chan;
  } mcas_seq_t;

endpackage

// ==== verif/mcas_adc_model.sv ====
// converter core stand-in: one fixed code per channel
// assumes seq carries hold and channel on the system clock
module mcas_adc_model #(
  parameter logic [43:0] CODES = 44'h0
) (
  // clock and sequencer controls
  input wire logic aclk,
  input wire mcas_pkg::mcas_seq_t seq,
  // code back to the sequencer
  output logic [10:0] adc_code_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // known start value, else the idle code would stay unknown forever
  logic [10:0] last_q = 11'h000;
  // twos complement code
  // outside hold the code toggles so a stale sample never matches
  assign adc_code_in = seq.hold ? CODES[seq.chan*11 +: 11] : ~last_q;
  always_ff @(posedge aclk)
  begin
    last_q <= adc_code_in;
  end
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the motor current adc sequencer
// assumes the converter stand-in and a 25 MHz system clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [43:0] CODES = {11'h555, 11'h001, 11'h3FF, 11'h400};
  localparam int CV = mcas_pkg::CONV_CYCLES;
  localparam int AQ = mcas_pkg::ACQ_CYCLES;
  localparam logic [1:0] OK = mcas_pkg::RESP_OKAY;
  logic aclk, aresetn, start, sync, irq_n, irq_oe, irq_line;
  logic awvalid, awready, wvalid, wready, bvalid;
  logic arvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, first_ch;
  logic [10:0] code;
  mcas_pkg::mcas_seq_t seq;
  int n_fail, n_checks, hold_n, acq_n;
  int ch_n [4];

  mcas_sequencer #(.PWM_PERIOD_INIT(12'h020)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .conversion_start_in(start),
    .adc_code_in(code), .seq_o(seq), .pwm_cycle_sync_out(sync),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe)
  );
  mcas_adc_model #(.CODES(CODES)) u_adc (
    .aclk(aclk), .seq(seq), .adc_code_in(code)
  );
  // external pull-up on the open-drain request line
  assign irq_line = irq_oe ? irq_n : 1'b1;

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (seq.hold && hold_n == 0)
      first_ch = seq.chan;
    if (seq.hold)
      ch_n[seq.chan]++;
    hold_n += seq.hold;
    acq_n += (seq.busy && !seq.hold);
  end

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [11:0] d,
                    input logic [1:0] er);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {20'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_ok && w_ok))
    begin
      @(posedge aclk);
      a_ok = a_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      awvalid <= !a_ok;
      wvalid <= !w_ok;
    end
    while (!bvalid) @(posedge aclk);
    chk(bresp, er, "bresp");
  endtask

  task automatic rc(input logic [3:0] idx, input logic [31:0] exp,
                    input logic [1:0] er, input string m);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    chk(rresp, er, "rresp");
    chk(rdata, exp, m);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // clear of the 20-cycle acquisition after reset
    repeat (30) @(posedge aclk);
  endtask

  task automatic kick();
    start <= 1'b1;
    repeat (2) @(posedge aclk);
    start <= 1'b0;
  endtask

  task automatic go();
    hold_n = 0;
    acq_n = 0;
    ch_n = '{default: 0};
    kick();
    while (!seq.hold) @(posedge aclk);
    while (seq.busy) @(posedge aclk);
  endtask

  task automatic res_chk(input logic [3:0] sel);
    for (int c = 0; c < 4; c++)
    begin
      chk(ch_n[c], sel[c] ? CV : 0, "per channel");
      if (sel[c])
        rc(4'(mcas_pkg::IDX_RES_U + c), {20'h0, CODES[c*11 +: 11], 1'b0},
           OK, "result");
    end
  endtask

  task automatic t_regs();
    rc(mcas_pkg::IDX_CTRL, 32'h0, OK, "ctrl");
    rc(mcas_pkg::IDX_INT_ENABLE, 32'h3, OK, "int enable");
    rc(mcas_pkg::IDX_PWM_PERIOD, 32'h20, OK, "period");
    wr(mcas_pkg::IDX_CTRL, 12'hFDF, OK);
    rc(mcas_pkg::IDX_CTRL, 32'hFDC, OK, "ctrl rw");
    // low strobe only: the upper nibble must keep its ones
    wstrb <= 4'h1;
    wr(mcas_pkg::IDX_CTRL, 12'h000, OK);
    wstrb <= 4'hF;
    rc(mcas_pkg::IDX_CTRL, 32'hF00, OK, "strobe");
    wr(mcas_pkg::IDX_CTRL, 12'h000, OK);
    wr(4'h9, 12'h001, mcas_pkg::RESP_SLVERR);
    rc(4'h9, 32'h0, mcas_pkg::RESP_SLVERR, "unmapped");
  endtask

  task automatic t_two();
    go();
    chk(hold_n, 2 * CV, "two hold");
    chk(acq_n, AQ, "reacquire");
    chk(first_ch, mcas_pkg::CH_V, "first");
    res_chk(4'b0110);
    rc(mcas_pkg::IDX_STATUS, 32'h1, OK, "done");
    chk(irq_line, 1'b1, "no irq");
  endtask

  task automatic t_four();
    wr(mcas_pkg::IDX_CTRL, 12'h088, OK);
    go();
    chk(hold_n, 4 * CV, "four hold");
    chk(acq_n, AQ, "reacquire");
    chk(first_ch, mcas_pkg::CH_U, "first");
    res_chk(4'b1111);
    wr(mcas_pkg::IDX_RES_U, 12'hABC, OK);
    rc(mcas_pkg::IDX_RES_U, {20'h0, CODES[10:0], 1'b0}, OK, "ro");
    chk(irq_line, 1'b0, "irq low");
    rc(mcas_pkg::IDX_STATUS, 32'h1, OK, "done");
    repeat (2) @(posedge aclk);
    chk(irq_line, 1'b1, "irq freed");
  endtask

  task automatic t_defer();
    int n;
    wr(mcas_pkg::IDX_INT_ENABLE, 12'h000, OK);
    kick();
    while (!seq.hold) @(posedge aclk);
    while (seq.hold) @(posedge aclk);
    n = 1;
    kick();
    n += 2;
    while (!seq.hold)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n > AQ, 1'b1, "defer");
    while (seq.busy) @(posedge aclk);
    chk(irq_line, 1'b1, "masked");
    rc(mcas_pkg::IDX_STATUS, 32'h3, OK, "deferred");
    go();
    wr(mcas_pkg::IDX_INT_ENABLE, 12'h003, OK);
    repeat (2) @(posedge aclk);
    chk(irq_line, 1'b0, "unmasked");
    wr(mcas_pkg::IDX_INT_CLEAR, 12'h003, OK);
    repeat (2) @(posedge aclk);
    chk(irq_line, 1'b1, "cleared");
    rc(mcas_pkg::IDX_STATUS, 32'h0, OK, "cleared");
  endtask

  task automatic t_pwm();
    int n;
    while (!sync) @(posedge aclk);
    @(posedge aclk);
    chk(sync, 1'b0, "sync width");
    n = 1;
    while (!sync)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n, 32'h20, "sync period");
    wr(mcas_pkg::IDX_CTRL, 12'h020, OK);
    n = 0;
    while (!seq.hold)
    begin
      @(posedge aclk);
      n++;
    end
    chk(n <= 40, 1'b1, "sync start");
    wr(mcas_pkg::IDX_CTRL, 12'h000, OK);
    while (seq.busy) @(posedge aclk);
  endtask

  task automatic t_reset();
    wr(mcas_pkg::IDX_CTRL, 12'h088, OK);
    kick();
    repeat (40) @(posedge aclk);
    chk(seq.hold, 1'b1, "running");
    // a four-channel group would still hold here without the abort
    do_reset();
    // idle after reset parks the channel field on v
    chk(seq, {2'b00, mcas_pkg::CH_V}, "abort");
    rc(mcas_pkg::IDX_CTRL, 32'h0, OK, "ctrl");
    rc(mcas_pkg::IDX_STATUS, 32'h0, OK, "status");
    chk(irq_line, 1'b1, "irq");
    t_two();
  endtask

  initial
  begin
    {start, awvalid, wvalid, arvalid} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    n_fail = 0;
    n_checks = 0;
    do_reset();
    t_regs();
    t_two();
    t_four();
    t_defer();
    t_pwm();
    t_reset();
    wrap_up();
  end

  // about 1400 cycles are needed; a hang ends here
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    wrap_up();
  end
endmodule
